// ---- hw/fetch_execute_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module fetch_execute_core
  import core_pkg::*;
#(
  parameter int PC_WIDTH = PC_WIDTH_DEF
)(
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  output logic      [PC_WIDTH-1:0]    prog_addr,
  input  wire logic [INSTR_WIDTH-1:0] prog_data,
  input  wire logic                   interrupt_request,
  input  wire logic                   master_reset_pin,
  output logic                        reset_pin_pullup,
  output logic                        cycle_rate_output,
  output logic                        cycle_rate_oe,
  output phase_strobes_t              phase_strobes
);

  // Target forming uses the 8-bit low byte plus latch bits
  if (PC_WIDTH < 9 || PC_WIDTH > 13)
  begin : g_width_check
    $error("PC_WIDTH must lie between 9 and 13");
  end

  phase_t                 phase;
  phase_t                 next_phase;
  ctrl_t                  ctrl;
  flags_t                 flags;
  alu_out_t               alu;
  logic [PC_WIDTH-1:0]    pc;
  logic [PC_WIDTH-1:0]    redirect_target;
  logic [INSTR_WIDTH-1:0] fetched;
  logic [INSTR_WIDTH-1:0] ir;
  logic                   fetch_valid;
  logic                   ir_valid;
  logic [7:0]             acc;
  logic [7:0]             operand;
  logic [7:0]             pointer;
  logic [4:0]             pc_latch;
  logic [7:0]             ram [128];
  logic [6:0]             eff_addr;
  logic                   pin_reset;
  logic                   commit;
  logic                   pcl_write;
  logic                   take_jump;
  logic                   int_accept;
  logic                   redirect;
  logic                   bus_ack;

  // Reset pin only acts when the shared pin is given that role
  assign pin_reset        = ctrl.reset_pin_sel && !master_reset_pin;
  assign reset_pin_pullup = ctrl.reset_pin_sel;

  // Phase sequencer: divide by four
  always_comb
  begin
    case (phase)
      phase_one:   next_phase = phase_two;
      phase_two:   next_phase = phase_three;
      phase_three: next_phase = phase_four;
      default:     next_phase = phase_one;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase <= phase_one;
    else if (pin_reset)
      phase <= phase_one;
    else
      phase <= next_phase;
  end

  // Strobes registered so they are glitch free at the port
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_strobes <= '0;
    else
    begin
      phase_strobes.one   <= (next_phase == phase_one) || pin_reset;
      phase_strobes.two   <= (next_phase == phase_two) && !pin_reset;
      phase_strobes.three <= (next_phase == phase_three) && !pin_reset;
      phase_strobes.four  <= (next_phase == phase_four) && !pin_reset;
    end
  end

  // Effective file address, indirect through the pointer at location zero
  assign eff_addr = (ir[6:0] == SFR_INDIRECT) ? pointer[6:0] : ir[6:0];

  // Data memory view: special registers overlay the RAM
  function automatic logic [7:0] file_read(input logic [6:0] a);
    if (a == SFR_INDIRECT)
      file_read = 8'h00;
    else if (a == SFR_PC_LOW)
      file_read = pc[7:0];
    else if (a == SFR_FLAGS)
      file_read = {5'h00, flags};
    else if (a == SFR_POINTER)
      file_read = pointer;
    else if (a == SFR_PC_LATCH)
      file_read = {3'h0, pc_latch};
    else
      file_read = ram[a];
  endfunction

  // ALU and decode; accumulator is one input, file or literal the other
  always_comb
  begin
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [8:0] sum;
    logic [4:0] nib;
    a   = (ir[13:12] == GRP_LIT) ? ir[7:0] : operand;
    b   = acc;
    cin = 1'b0;
    if ((ir[13:12] == GRP_FILE && ir[11:8] == OP_SUB) ||
        (ir[13:12] == GRP_LIT && ir[11:9] == LIT_SUB))
    begin
      b   = ~acc; // Two's complement subtract: carry out means no borrow
      cin = 1'b1;
    end
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    alu = '0;
    alu.carry = sum[8];
    alu.digit = nib[4];
    if (ir[13:12] == GRP_FILE)
    begin
      alu.to_file = ir[7];
      alu.to_acc  = !ir[7];
      alu.upd_z   = 1'b1;
      case (ir[11:8])
        OP_MOVE_TO:
        begin
          alu.result = acc;
          alu.to_acc = 1'b0;
          alu.upd_z  = 1'b0;
        end
        OP_CLEAR:  alu.result = 8'h00;
        OP_SUB, OP_ADD:
        begin
          alu.result = sum[7:0];
          alu.upd_c  = 1'b1;
          alu.upd_dc = 1'b1;
        end
        OP_DEC:    alu.result = operand - 8'h01;
        OP_OR:     alu.result = operand | acc;
        OP_AND:    alu.result = operand & acc;
        OP_XOR:    alu.result = operand ^ acc;
        OP_MOVE:   alu.result = operand;
        OP_INVERT: alu.result = ~operand;
        OP_INC:    alu.result = operand + 8'h01;
        OP_ROT_R, OP_ROT_L:
        begin
          alu.result = (ir[8]) ? {operand[6:0], flags.arith_overflow_flag}
                               : {flags.arith_overflow_flag, operand[7:1]};
          alu.carry  = (ir[8]) ? operand[7] : operand[0];
          alu.upd_c  = 1'b1;
          alu.upd_z  = 1'b0;
        end
        OP_SWAP:
        begin
          alu.result = {operand[3:0], operand[7:4]};
          alu.upd_z  = 1'b0;
        end
        default:
        begin
          alu.to_file = 1'b0; // Unsupported codes execute as no-ops
          alu.to_acc  = 1'b0;
          alu.upd_z   = 1'b0;
        end
      endcase
    end
    else if (ir[13:12] == GRP_LIT)
    begin
      alu.to_acc = 1'b1;
      alu.upd_z  = 1'b1;
      if (ir[11:10] == LIT_MOVE)
      begin
        alu.result = ir[7:0];
        alu.upd_z  = 1'b0;
      end
      else if (ir[11:9] == LIT_SUB || ir[11:9] == LIT_ADD)
      begin
        alu.result = sum[7:0];
        alu.upd_c  = 1'b1;
        alu.upd_dc = 1'b1;
      end
      else if (ir[11:8] == OP_OR + OP_MOVE - OP_OR) // Literal OR shares the move code
        alu.result = ir[7:0] | acc;
      else if (ir[11:8] == OP_INVERT)
        alu.result = ir[7:0] & acc;
      else if (ir[11:8] == OP_INC)
        alu.result = ir[7:0] ^ acc;
      else
      begin
        alu.to_acc = 1'b0;
        alu.upd_z  = 1'b0;
      end
    end
    else if (ir[13:12] == GRP_JUMP)
      alu.jump = ir[11]; // Only the unconditional jump form is served
  end

  // Redirect decisions taken at the end of the execute cycle
  assign commit     = (phase == phase_four) && ir_valid;
  assign pcl_write  = commit && alu.to_file && (eff_addr == SFR_PC_LOW);
  assign take_jump  = commit && (alu.jump || pcl_write);
  assign int_accept = (phase == phase_four) && ctrl.gie && interrupt_request && !take_jump;
  assign redirect   = take_jump || int_accept;

  always_comb
  begin
    if (commit && alu.jump)
      redirect_target = PC_WIDTH'({pc_latch[4:3], ir[10:0]});
    else if (pcl_write)
      redirect_target = PC_WIDTH'({pc_latch, alu.result});
    else
      redirect_target = PC_WIDTH'(INT_VECTOR);
  end

  // Fetch stage: address out at phase_one, word captured at phase_four
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc          <= PC_WIDTH'(RESET_VECTOR);
      prog_addr   <= '0;
      fetched     <= '0;
      fetch_valid <= 1'b0;
    end
    else if (pin_reset)
    begin
      pc          <= PC_WIDTH'(RESET_VECTOR);
      prog_addr   <= PC_WIDTH'(RESET_VECTOR); // Memory parked at the reset vector
      fetch_valid <= 1'b0;
    end
    else if (phase == phase_one)
    begin
      prog_addr <= pc;
      pc        <= pc + PC_WIDTH'(1);
    end
    else if (phase == phase_four)
    begin
      if (redirect)
      begin
        pc          <= redirect_target;
        fetch_valid <= 1'b0; // Flush the word fetched behind the branch
      end
      else
      begin
        fetched     <= prog_data; // Whole word in one access
        fetch_valid <= 1'b1;
      end
    end
  end

  // Execute stage: load at phase_one, operand at phase_two
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ir       <= '0;
      ir_valid <= 1'b0;
      operand  <= 8'h00;
    end
    else if (pin_reset)
      ir_valid <= 1'b0;
    else if (phase == phase_one)
    begin
      ir       <= fetched;     // Overlaps with the next fetch
      ir_valid <= fetch_valid;
    end
    else if (phase == phase_two)
      operand <= file_read(eff_addr);
  end

  // Result write-back in phase_four; RAM holds no reset
  always_ff @(posedge sys_clk)
  begin
    if (commit && alu.to_file && !pin_reset)
      ram[eff_addr] <= alu.result;
  end

  // Accumulator, pointer, latch and flags; the accumulator has no file address
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc      <= 8'h00;
      pointer  <= 8'h00;
      pc_latch <= 5'h00;
      flags    <= '0;
    end
    else if (commit && !pin_reset)
    begin
      if (alu.to_acc)
        acc <= alu.result;
      if (alu.to_file && eff_addr == SFR_POINTER)
        pointer <= alu.result;
      if (alu.to_file && eff_addr == SFR_PC_LATCH)
        pc_latch <= alu.result[4:0];
      // ALU flag updates override a direct write to the flag location
      flags.arith_overflow_flag  <= alu.upd_c ? alu.carry
        : (alu.to_file && eff_addr == SFR_FLAGS) ? alu.result[0] : flags.arith_overflow_flag;
      flags.nibble_overflow_flag <= alu.upd_dc ? alu.digit
        : (alu.to_file && eff_addr == SFR_FLAGS) ? alu.result[1] : flags.nibble_overflow_flag;
      flags.result_nil_flag      <= alu.upd_z ? (alu.result == 8'h00)
        : (alu.to_file && eff_addr == SFR_FLAGS) ? alu.result[2] : flags.result_nil_flag;
    end
  end

  // Cycle-rate output: high for phases one and two, only in the RC modes
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cycle_rate_output <= 1'b0;
      cycle_rate_oe     <= 1'b0;
    end
    else
    begin
      cycle_rate_oe     <= ctrl.cycle_out_en &&
                           (ctrl.osc_mode == outside_rc_mode || ctrl.osc_mode == onchip_rc_mode);
      cycle_rate_output <= ctrl.cycle_out_en &&
                           (ctrl.osc_mode == outside_rc_mode || ctrl.osc_mode == onchip_rc_mode) &&
                           (next_phase == phase_one || next_phase == phase_two);
    end
  end

  // Bus slave: one wait cycle, so read data can come from a flop
  assign waitrequest = (read || write) && !bus_ack;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_ack  <= 1'b0;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      bus_ack <= (read || write) && !bus_ack;
      if (read && !bus_ack)
      begin
        if (address == CTRL_OFS)
          readdata <= {27'h0, ctrl};
        else if (address == CORE_STAT_OFS)
          readdata <= (32'(pc) | (32'(fetch_valid) << STAT_FETCH_VALID_BIT)
                      | (32'(ir_valid) << STAT_IR_VALID_BIT)
                      | (32'(phase) << STAT_PHASE_LSB));
        else if (address == ALU_STAT_OFS)
          readdata <= 32'(acc) | (32'(flags) << ALU_STAT_FLAGS_LSB);
        else
          readdata <= 32'h0000_0000; // Unmapped offsets read zero
      end
    end
  end

  // Control register; an accepted interrupt disarms further interrupts
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl <= ctrl_t'(CTRL_RESET);
    else if (write && bus_ack && address == CTRL_OFS)
      ctrl <= ctrl_t'(writedata[4:0]); // Software write wins over disarm
    else if (int_accept)
      ctrl.gie <= 1'b0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_phase_order: assert property (((phase == phase_one) && !pin_reset) [*4] |->
    1'b0) else $error("phase one held for four cycles");
  // A pin reset restarts the sequence, so only reset-free windows are judged
  chk_phase_cycle: assert property (phase == phase_one && !pin_reset ##1 !pin_reset [*2] |=>
    phase == phase_four && $past(phase) == phase_three && $past(phase, 2) == phase_two
    ##1 phase == phase_one)
    else $error("phases out of order");
  chk_pc_advance: assert property (phase == phase_one && !pin_reset |=>
    pc == $past(pc) + PC_WIDTH'(1) && prog_addr == $past(pc))
    else $error("program counter did not advance in phase one");
  chk_ir_load: assert property (phase == phase_one && !pin_reset |=>
    ir == $past(fetched) && ir_valid == $past(fetch_valid))
    else $error("instruction register not loaded from prefetch");
  chk_write_phase: assert property (commit && alu.to_file && !pin_reset &&
    eff_addr > SFR_PC_LATCH |=> ram[$past(eff_addr)] == $past(alu.result))
    else $error("result not written back in phase four");
  chk_branch_flush: assert property (take_jump && !pin_reset |=>
    !fetch_valid && pc == $past(redirect_target) ##1 !ir_valid[*4])
    else $error("prefetched word not flushed on branch");
  chk_zero_flag: assert property (commit && alu.upd_z && !pin_reset |=>
    flags.result_nil_flag == ($past(alu.result) == 8'h00))
    else $error("zero flag does not follow result");
  chk_acc_hidden: assert property (acc != $past(acc) |-> $past(commit))
    else $error("accumulator changed outside execute commit");
  chk_int_vector: assert property (int_accept && !pin_reset |=>
    pc == PC_WIDTH'(INT_VECTOR) && !ctrl.gie ##4 !ir_valid)
    else $error("interrupt did not redirect to vector");
  chk_reset_pin: assert property (pin_reset |=> !fetch_valid && !ir_valid &&
    pc == PC_WIDTH'(RESET_VECTOR) && reset_pin_pullup)
    else $error("reset pin did not clear the pipeline");
  // Control writes and pin resets inside the window legally reshape the output
  chk_rate_out: assert property (phase == phase_three && !pin_reset &&
    !(write && bus_ack) ##1 cycle_rate_oe && !pin_reset && !(write && bus_ack) ##1 1'b1 |=>
    !$past(cycle_rate_output, 2) && $past(cycle_rate_output) && cycle_rate_output)
    else $error("cycle rate output not at a quarter of the clock");

  cov_branch:    cover property (take_jump);
  cov_interrupt: cover property (int_accept);
  cov_borrow:    cover property (commit && alu.upd_c && !alu.carry);
  cov_bus_read:  cover property (read && !waitrequest && address == CORE_STAT_OFS);

endmodule
`default_nettype wire

// ---- hw/core_pkg.sv ----
package core_pkg;

  // Phase timing: one instruction cycle spans this many input clocks
  localparam int PHASES_PER_CYCLE = 4;
  localparam int INSTR_WIDTH      = 14;
  localparam int PC_WIDTH_DEF     = 13;

  // Fetch vectors
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] INT_VECTOR   = 13'h0004;

  // Register bus byte offsets
  localparam logic [3:0] CTRL_OFS      = 4'h0;
  localparam logic [3:0] CORE_STAT_OFS = 4'h4;
  localparam logic [3:0] ALU_STAT_OFS  = 4'h8;
  localparam logic [4:0] CTRL_RESET    = 5'h00;

  // Core and ALU status word field positions
  localparam int STAT_FETCH_VALID_BIT = 16;
  localparam int STAT_IR_VALID_BIT    = 17;
  localparam int STAT_PHASE_LSB       = 20;
  localparam int ALU_STAT_FLAGS_LSB   = 8;

  // Special locations of the data memory
  localparam logic [6:0] SFR_INDIRECT = 7'h00;
  localparam logic [6:0] SFR_PC_LOW   = 7'h02;
  localparam logic [6:0] SFR_FLAGS    = 7'h03;
  localparam logic [6:0] SFR_POINTER  = 7'h04;
  localparam logic [6:0] SFR_PC_LATCH = 7'h0a;

  // Instruction groups and operations
  localparam logic [1:0] GRP_FILE = 2'b00;
  localparam logic [1:0] GRP_JUMP = 2'b10;
  localparam logic [1:0] GRP_LIT  = 2'b11;
  localparam logic [3:0] OP_MOVE_TO = 4'h0;
  localparam logic [3:0] OP_CLEAR   = 4'h1;
  localparam logic [3:0] OP_SUB     = 4'h2;
  localparam logic [3:0] OP_DEC     = 4'h3;
  localparam logic [3:0] OP_OR      = 4'h4;
  localparam logic [3:0] OP_AND     = 4'h5;
  localparam logic [3:0] OP_XOR     = 4'h6;
  localparam logic [3:0] OP_ADD     = 4'h7;
  localparam logic [3:0] OP_MOVE    = 4'h8;
  localparam logic [3:0] OP_INVERT  = 4'h9;
  localparam logic [3:0] OP_INC     = 4'ha;
  localparam logic [3:0] OP_ROT_R   = 4'hc;
  localparam logic [3:0] OP_ROT_L   = 4'hd;
  localparam logic [3:0] OP_SWAP    = 4'he;
  localparam logic [1:0] LIT_MOVE   = 2'b00;
  localparam logic [2:0] LIT_SUB    = 3'b110;
  localparam logic [2:0] LIT_ADD    = 3'b111;

  typedef enum logic [1:0] {phase_one, phase_two, phase_three, phase_four} phase_t;
  typedef enum logic [1:0] {osc_low_power, osc_crystal, outside_rc_mode, onchip_rc_mode} osc_mode_t;

  typedef struct packed {
    logic      gie;
    logic      reset_pin_sel;
    osc_mode_t osc_mode;
    logic      cycle_out_en;
  } ctrl_t;

  typedef struct packed {
    logic result_nil_flag;
    logic nibble_overflow_flag;
    logic arith_overflow_flag;
  } flags_t;

  typedef struct packed {
    logic one;
    logic two;
    logic three;
    logic four;
  } phase_strobes_t;

  typedef struct packed {
    logic [7:0] result;
    logic       to_file;
    logic       to_acc;
    logic       upd_c;
    logic       upd_dc;
    logic       upd_z;
    logic       carry;
    logic       digit;
    logic       jump;
  } alu_out_t;

endpackage

// ---- tb/prog_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module prog_mem
  import core_pkg::*;
#(
  parameter int LAT = 1
)(
  input  wire logic                   sys_clk,
  input  wire logic [12:0]            prog_addr,
  output logic      [INSTR_WIDTH-1:0] prog_data
);
  logic [INSTR_WIDTH-1:0] rom [16];
  logic [INSTR_WIDTH-1:0] prev = '0;
  logic [12:0]            last = '0;
  int                     age  = 0;
  // Settling time after each address change; the word is ready only in the third cycle,
  // the last one the core allows, so early sampling shows up as junk
  always_ff @(posedge sys_clk)
  begin
    age  <= (prog_addr !== last) ? 0 : ((age < LAT) ? age + 1 : age);
    last <= prog_addr;
    prev <= prog_data;
  end
  // Toggling junk until settled, alternating between the inverted stale word and the stale word itself
  assign prog_data = (age >= LAT && prog_addr === last) ? rom[prog_addr[3:0]] : ~prev;
endmodule
`default_nettype wire

// ---- tb/two_stage_fetch_execute_core_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module two_stage_fetch_execute_core_test
  import core_pkg::*;
;
  logic           sys_clk = 0;
  logic           reset_n = 0;
  logic           read = 0;
  logic           write = 0;
  logic           interrupt_request = 0;
  logic           master_reset_pin = 1;
  logic [3:0]     address = '0;
  logic [31:0]    writedata = '0;
  logic [31:0]    readdata;
  logic           waitrequest;
  logic [12:0]    prog_addr;
  logic [13:0]    prog_data;
  logic           reset_pin_pullup;
  logic           cycle_rate_output;
  logic           cycle_rate_oe;
  phase_strobes_t phase_strobes;
  int             failures = 0;
  int             n_tests = 0;
  logic [13:0]    progs [8][10];
  logic [10:0]    expv [8];
  logic [31:0]    rd;
  logic [7:0]     s;
  logic [3:0]     ps;
  logic [12:0]    pa;
  int             seq [9] = '{1, 2, 3, 4, 5, 7, 8, 9, 8};
  int             n;
  int             lc;

  fetch_execute_core uut (.sys_clk(sys_clk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .prog_addr(prog_addr), .prog_data(prog_data),
    .interrupt_request(interrupt_request), .master_reset_pin(master_reset_pin),
    .reset_pin_pullup(reset_pin_pullup), .cycle_rate_output(cycle_rate_output),
    .cycle_rate_oe(cycle_rate_oe), .phase_strobes(phase_strobes));

  prog_mem pm (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data));

  // Instruction word builders
  function automatic logic [13:0] lit(input logic [2:0] op, input logic [7:0] k);
    return {GRP_LIT, op, 1'b0, k};
  endfunction
  function automatic logic [13:0] fw(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {GRP_FILE, op, d, f};
  endfunction
  function automatic logic [13:0] jmp(input logic [10:0] a);
    return {GRP_JUMP, 1'b1, a};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One Avalon access; the idle edge in front keeps a release and a new request apart
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    address   <= a;
    writedata <= d;
    read      <= !w;
    write     <= w;
    k = 0;
    // Waitrequest and read data are judged as the core sees them at this very edge
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 20);
    q = readdata;
    if (k >= 20)
      failures++;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask

  initial forever #5 sys_clk = ~sys_clk;

  // Cuts a hang short
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  initial
  begin
    progs[0] = '{lit(3'b000, 8'h0f), lit(LIT_ADD, 8'h01), fw(OP_MOVE_TO, 1, 7'h20),
      lit(LIT_SUB, 8'h10), jmp(7), lit(3'b000, 8'haa), lit(3'b000, 8'hbb),
      fw(OP_ADD, 0, 7'h20), jmp(8), 14'h0};
    progs[1] = '{0: lit(3'b000, 8'h0f), 1: lit(LIT_ADD, 8'h01), 2: jmp(2), default: 14'h0};
    progs[2] = '{0: lit(3'b000, 8'h01), 1: lit(LIT_SUB, 8'h11), 2: jmp(2), default: 14'h0};
    progs[3] = '{0: lit(3'b000, 8'h80), 1: lit(LIT_ADD, 8'h80), 2: jmp(2), default: 14'h0};
    progs[4] = '{0: lit(3'b000, 8'h3c), 1: fw(OP_MOVE_TO, 1, 7'h21), 2: fw(OP_SWAP, 0, 7'h21),
      3: lit(LIT_ADD, 8'h00), 4: jmp(4), default: 14'h0};
    progs[5] = '{0: lit(3'b000, 8'h05), 1: fw(OP_MOVE_TO, 1, SFR_PC_LOW), 2: lit(3'b000, 8'haa),
      3: lit(3'b000, 8'hbb), 4: lit(LIT_ADD, 8'h10), 5: lit(LIT_ADD, 8'h01), 6: jmp(6),
      default: 14'h0};
    progs[6] = '{0: jmp(0), 4: lit(3'b000, 8'h5a), 5: lit(LIT_ADD, 8'h00), 6: jmp(6),
      default: 14'h0};
    // Literal OR, AND, XOR, then a rotate through carry of a stored byte
    progs[7] = '{0: lit(3'b000, 8'h96), 1: {GRP_LIT, OP_MOVE, 8'h09},
      2: {GRP_LIT, OP_INVERT, 8'hf0}, 3: {GRP_LIT, OP_INC, 8'h90}, 4: lit(3'b000, 8'h81),
      5: fw(OP_MOVE_TO, 1, 7'h22), 6: fw(OP_ROT_L, 0, 7'h22), 7: jmp(7), default: 14'h0};
    // Expected {zero, digit, carry, accumulator}
    expv = '{11'h010, 11'h210, 11'h310, 11'h500, 11'h0c3, 11'h006, 11'h05a, 11'h502};
    for (int a = 0; a < 16; a++)
      pm.rom[a] = 14'h0;
    do_reset();
    repeat (2) @(posedge sys_clk);
    #1;
    // Strobes rotate one-hot through the four phases
    for (int i = 0; i < 8; i++)
    begin
      ps = phase_strobes;
      @(posedge sys_clk);
      #1;
      check($countones(ps), 1);
      check(32'(phase_strobes), 32'({ps[0], ps[3:1]}));
    end
    bus(0, CTRL_OFS, 32'h0, rd);
    check(rd, 32'(CTRL_RESET));
    bus(1, CTRL_OFS, 32'h07, rd);
    bus(0, CTRL_OFS, 32'h0, rd);
    check(rd, 32'h07);
    s = '0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      #1;
      s = {s[6:0], cycle_rate_output};
    end
    check(32'(cycle_rate_oe), 1);
    check($countones(s), 4);
    check(32'(s[7:4]), 32'(s[3:0]));
    bus(1, CTRL_OFS, 32'h03, rd);
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(cycle_rate_oe), 0);
    // The other RC mode drives the pin as well
    bus(1, CTRL_OFS, 32'h05, rd);
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(cycle_rate_oe), 1);
    bus(0, 4'hc, 32'h0, rd);
    check(rd, 32'h0);
    // Pin reset keeps fetch at the reset vector while low
    bus(1, CTRL_OFS, 32'h08, rd);
    master_reset_pin <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    check(32'(prog_addr), 32'(RESET_VECTOR));
    check(32'(reset_pin_pullup), 1);
    // Held in reset: counter at the vector, pipeline empty, phase one
    bus(0, CORE_STAT_OFS, 32'h0, rd);
    check(rd, 32'(RESET_VECTOR));
    @(posedge sys_clk);
    master_reset_pin <= 1'b1;
    // Each program ends in a self loop so the final state is stable when read
    for (int p = 0; p < 8; p++)
    begin
      for (int a = 0; a < 16; a++)
        pm.rom[a] = (a < 10) ? progs[p][a] : 14'h0;
      do_reset();
      if (p == 0)
      begin
        pa = '0;
        n = 0;
        lc = 0;
        for (int c = 0; c < 60 && n < 9; c++)
        begin
          @(posedge sys_clk);
          #1;
          if (prog_addr !== pa)
          begin
            check(32'(prog_addr), seq[n]);
            if (n > 0)
              check(c - lc, PHASES_PER_CYCLE);
            lc = c;
            pa = prog_addr;
            n++;
          end
        end
        check(n, 9);
      end
      if (p == 6)
      begin
        bus(1, CTRL_OFS, 32'h10, rd);
        interrupt_request <= 1'b1;
      end
      repeat (80) @(posedge sys_clk);
      interrupt_request <= 1'b0;
      bus(0, ALU_STAT_OFS, 32'h0, rd);
      check(32'(rd[10:0]), 32'(expv[p]));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
